/* verilog/fisl_cfg.svh */
// fisl_cfg.svh: offsets, field positions, reset values and timing counts
// assumes 32-bit classic wishbone, one register per aligned word, mclk at 100 MHz
`ifndef FISL_CFG_SVH
`define FISL_CFG_SVH

// register indices; byte address is four times the index
`define FISL_IDX_TOP_REQ      10'h003
`define FISL_IDX_ALARM2_LATCH 10'h005
`define FISL_IDX_ERROR_LATCH  10'h006
`define FISL_IDX_OVFL_LATCH   10'h007
`define FISL_IDX_TIME_LATCH   10'h008
`define FISL_IDX_ALARM2_EN    10'h00d
`define FISL_IDX_ERROR_EN     10'h00e
`define FISL_IDX_OVFL_EN      10'h00f
`define FISL_IDX_TIME_EN      10'h010
`define FISL_IDX_MODE         10'h020
`define FISL_IDX_HOLD         10'h046

// alarm2 latch fields
`define FISL_A2_ONE_SECOND_TICK   0
`define FISL_A2_TXALIGN  1
`define FISL_A2_UNUSED   2
`define FISL_A2_TXCLK    3
`define FISL_A2_SHORT    4
`define FISL_A2_DENSITY  5
`define FISL_A2_LOOPUP   6
`define FISL_A2_LOOP_DEACTIVATE_CODE_EVT   7

// error latch fields
`define FISL_ER_FRAME    0
`define FISL_ER_MFAS     1
`define FISL_ER_SIGPAT   2
`define FISL_ER_CRC      3
`define FISL_ER_JITTER   4
`define FISL_ER_CLKADJ   5
`define FISL_ER_RXSLIP   6
`define FISL_ER_TXSLIP   7

// mode register fields
`define FISL_MD_E1       0
`define FISL_MD_CRCMODE  1
`define FISL_MD_AUTOADJ  2
`define FISL_MD_DENSITY  3
`define FISL_MD_PINIO    4

// hold register fields
`define FISL_HD_ALARM    0
`define FISL_HD_ERROR    1

`define FISL_RST_BYTE    8'h00
`define FISL_RST_MODE    8'h00
`define FISL_RST_HOLD    8'h03

`define FISL_CLK_NS      10
`define FISL_ONE_SECOND_TICK_NS   1000000000
`define FISL_ONE_SECOND_TICK_CYC  (`FISL_ONE_SECOND_TICK_NS / `FISL_CLK_NS)

`endif

/* verilog/fisl_pkg.sv */
// fisl_pkg.sv: types shared by the status latch block and its bench
// assumes fisl_cfg.svh supplies every numeric constant
`default_nettype none
package fisl_pkg;

  // live levels of the dual-edge alarm detectors
  typedef struct packed {
    logic loop_deactivate_code_evt;
    logic loop_activate_code_evt;
    logic driver_short_evt;
    logic tx_clock_loss_evt;
    logic tx_align_loss_evt;
  } fisl_alarm2_live_s;

  // error sources; all levels or pulses on mclk, captured on rising edges
  typedef struct packed {
    logic tx_frame_slip;
    logic tx_uncontrolled_slip;
    logic rx_frame_slip;
    logic rx_uncontrolled_slip;
    logic jitter_clock_adjusting;
    logic tx_store_err;
    logic rx_store_err;
    logic block_checksum_err;
    logic signaling_pattern_err;
    logic multiframe_pattern_err;
    logic framing_bit_err;
  } fisl_error_src_s;

  // timebase markers in latch bit order, msb first
  typedef struct packed {
    logic tx_signaling_mf_mark;
    logic tx_sysbus_mf_mark;
    logic tx_multiframe_mark;
    logic tx_frame_mark;
    logic rx_signaling_update;
    logic rx_sysbus_mf_mark;
    logic rx_multiframe_mark;
    logic rx_frame_mark;
  } fisl_timebase_s;

  typedef logic [7:0] fisl_byte_t;

endpackage : fisl_pkg
`default_nettype wire

/* verilog/fisl_latches.sv */
// fisl_latches.sv: four read-clear interrupt status latches with enables
// assumes event sources run on mclk; only the one-second pin is asynchronous
// Function
// RL1 - alarm2 bits catch both edges, except one-second tick and density flag
// RL2 - any live alarm2 change sets its bit, held per alarm hold mode
// RL3 - alarm2 event requests interrupt only when its enable bit set
// RL4 - density bit acts only with enforcement on, set by forced ones
// RL5 - one-second bit from internal timer or pin rising edge, per pin mode
// RL6 - loop-down, loop-up, short, tx clock, tx align flag any change
// RL7 - error bits rising edge, held per error hold mode, enable gates request
// RL8 - each slip bit set by frame slip or uncontrolled slip
// RL9 - clock error bit disabled without auto adjust, else follows adjustment activity
// RL10 - jitter bit flags either elastic store under-run or overflow
// RL11 - checksum error bit works only in crc modes, else reads zero
// RL12 - signaling and multiframe pattern bits only in e1, zero in t1
// RL13 - frame error bit set by framing bit or alignment pattern errors; code sets it from framing_bit_err alone
// RL14 - overflow bit latches at counter maximum only while its enable set
// RL15 - overflow bits held until the overflow register is read
// RL16 - overflow bit order: frame, alignment, severe, pattern, far-end, lcv, crc, framing
// RL17 - timebase bits rising edge, held until read, enable gates request
// RL18 - signaling and system bus multiframe markers latch at multiframe start
// RL19 - transmit multiframe marker latches at each transmit multiframe start
// RL20 - frame markers latch at each frame start
// RL21 - signaling update bit set by new stack signaling, cleared by read
// RL22 - receive multiframe marker latches at each received multiframe start
// RL23 - enabled event drives irq_n low and sets top request bit
// RL24 - software reads live status to tell rising from falling edge
// RL25 - unused alarm2 bit 2 always reads zero, writes ignored
`include "fisl_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module fisl_latches
  import fisl_pkg::*;
#(
  parameter int unsigned ONE_SECOND_TICK_CYCLES = `FISL_ONE_SECOND_TICK_CYC
)
(
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [11:0]       wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output var  logic [31:0]       wb_dat_o,
  output var  logic              wb_ack_o,
  input  wire fisl_alarm2_live_s alarm2_live_status,
  input  wire logic              tx_density_forced_evt,
  input  wire logic              one_second_pin,
  input  wire fisl_error_src_s   err_src,
  input  wire logic [7:0]        counter_at_max,
  input  wire fisl_timebase_s    timebase_src,
  output var  logic              one_second_tick,
  output var  logic              irq_n
);

  localparam int NREG = 4;

  logic [7:0]          alarm2_enable_q;
  logic [7:0]          error_enable_q;
  logic [7:0]          overflow_enable_q;
  logic [7:0]          timebase_enable_q;
  logic [7:0]          mode_q;
  logic [7:0]          hold_q;
  logic [3:0]          top_request_reg;
  logic [31:0]         latch_q;
  logic [31:0]         set_d;
  logic [NREG-1:0]     rd_clr;
  logic [NREG-1:0]     hold_en;
  logic [31:0]         rd_dat_d;
  logic                req;
  logic                wr_lo;
  logic [9:0]          idx;
  fisl_alarm2_live_s   live_prev_q;
  fisl_error_src_s     err_prev_q;
  logic [7:0]          cmax_prev_q;
  fisl_timebase_s      tb_prev_q;
  logic                pin_meta_q;
  logic                pin_sync_q;
  logic                pin_prev_q;
  logic [31:0]         sec_cnt_q;
  logic                sec_tick_q;
  logic                irq_n_q;
  logic [7:0]          a2_evt;
  logic [7:0]          er_evt;
  logic [7:0]          ov_evt;
  logic [7:0]          tb_evt;
  logic                slip_tx_now;
  logic                slip_tx_was;
  logic                slip_rx_now;
  logic                slip_rx_was;
  logic                jit_now;
  logic                jit_was;
  logic                sec_evt;
  logic [7:0]          a2_mask;
  logic [7:0]          er_mask;
  logic [31:0]         latch_vis;

  assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx   = wb_adr_i[11:2];
  assign wr_lo = req && wb_we_i && wb_sel_i[0];

  // bus answer: one cycle after the request, then dropped for one cycle
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req;
      if (req && !wb_we_i)
      begin
        wb_dat_o <= rd_dat_d;
      end
    end
  end

  // unmapped indices read as zero and still answer
  always_comb
  begin
    rd_dat_d = 32'h0000_0000;
    case (idx)
      `FISL_IDX_TOP_REQ:      rd_dat_d[3:0] = top_request_reg;
      `FISL_IDX_ALARM2_LATCH: rd_dat_d[7:0] = latch_vis[7:0];
      `FISL_IDX_ERROR_LATCH:  rd_dat_d[7:0] = latch_vis[15:8];
      `FISL_IDX_OVFL_LATCH:   rd_dat_d[7:0] = latch_vis[23:16];
      `FISL_IDX_TIME_LATCH:   rd_dat_d[7:0] = latch_vis[31:24];
      `FISL_IDX_ALARM2_EN:    rd_dat_d[7:0] = alarm2_enable_q;
      `FISL_IDX_ERROR_EN:     rd_dat_d[7:0] = error_enable_q;
      `FISL_IDX_OVFL_EN:      rd_dat_d[7:0] = overflow_enable_q;
      `FISL_IDX_TIME_EN:      rd_dat_d[7:0] = timebase_enable_q;
      `FISL_IDX_MODE:         rd_dat_d[7:0] = mode_q;
      `FISL_IDX_HOLD:         rd_dat_d[7:0] = hold_q;
      default:                rd_dat_d = 32'h0000_0000;
    endcase
  end

  // software control registers; writes to latch registers are ignored
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      alarm2_enable_q   <= `FISL_RST_BYTE;
      error_enable_q    <= `FISL_RST_BYTE;
      overflow_enable_q <= `FISL_RST_BYTE;
      timebase_enable_q <= `FISL_RST_BYTE;
      mode_q            <= `FISL_RST_MODE;
      hold_q            <= `FISL_RST_HOLD;
    end
    else if (wr_lo)
    begin
      case (idx)
        `FISL_IDX_ALARM2_EN: alarm2_enable_q   <= wb_dat_i[7:0];
        `FISL_IDX_ERROR_EN:  error_enable_q    <= wb_dat_i[7:0];
        `FISL_IDX_OVFL_EN:   overflow_enable_q <= wb_dat_i[7:0];
        `FISL_IDX_TIME_EN:   timebase_enable_q <= wb_dat_i[7:0];
        `FISL_IDX_MODE:      mode_q            <= wb_dat_i[7:0];
        `FISL_IDX_HOLD:      hold_q            <= wb_dat_i[7:0];
        default:             hold_q            <= hold_q;
      endcase
    end
  end

  // a read of a latch register clears it at the answering request edge
  always_comb
  begin
    rd_clr    = '0;
    rd_clr[0] = req && !wb_we_i && (idx == `FISL_IDX_ALARM2_LATCH);
    rd_clr[1] = req && !wb_we_i && (idx == `FISL_IDX_ERROR_LATCH);
    rd_clr[2] = req && !wb_we_i && (idx == `FISL_IDX_OVFL_LATCH);  // RL15
    rd_clr[3] = req && !wb_we_i && (idx == `FISL_IDX_TIME_LATCH);  // RL17
  end

  // overflow and timebase latches always hold until read
  // hold mode 0 lets alarm2 and error bits show only this cycle's event
  assign hold_en = {1'b1, 1'b1, hold_q[`FISL_HD_ERROR], hold_q[`FISL_HD_ALARM]}; // RL2 RL7 RL15

  // one-second pin is asynchronous; the first stage feeds only the second
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end
    else
    begin
      pin_meta_q <= one_second_pin;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  // internal one-second timer; the parameter lets a bench shorten it
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      sec_cnt_q  <= 32'h0000_0000;
      sec_tick_q <= 1'b0;
    end
    else if (sec_cnt_q == ONE_SECOND_TICK_CYCLES - 1)
    begin
      sec_cnt_q  <= 32'h0000_0000;
      sec_tick_q <= 1'b1;
    end
    else
    begin
      sec_cnt_q  <= sec_cnt_q + 32'h0000_0001;
      sec_tick_q <= 1'b0;
    end
  end

  assign sec_evt = mode_q[`FISL_MD_PINIO] ? (pin_sync_q && !pin_prev_q) : sec_tick_q; // RL5
  assign one_second_tick = sec_tick_q;

  // previous samples for edge detection
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      live_prev_q <= '0;
      err_prev_q  <= '0;
      cmax_prev_q <= 8'h00;
      tb_prev_q   <= '0;
    end
    else
    begin
      live_prev_q <= alarm2_live_status;
      err_prev_q  <= err_src;
      cmax_prev_q <= counter_at_max;
      tb_prev_q   <= timebase_src;
    end
  end

  // alarm2: dual edge for detectors, single edge for tick and density
  // the latch keeps no edge direction; software reads the live detector levels
  always_comb
  begin
    a2_evt = 8'h00;
    a2_evt[`FISL_A2_LOOP_DEACTIVATE_CODE_EVT]  = alarm2_live_status.loop_deactivate_code_evt
                               ^ live_prev_q.loop_deactivate_code_evt;        // RL6 RL1 RL24
    a2_evt[`FISL_A2_LOOPUP]  = alarm2_live_status.loop_activate_code_evt
                               ^ live_prev_q.loop_activate_code_evt;          // RL6
    a2_evt[`FISL_A2_SHORT]   = alarm2_live_status.driver_short_evt
                               ^ live_prev_q.driver_short_evt;                // RL6
    a2_evt[`FISL_A2_TXCLK]   = alarm2_live_status.tx_clock_loss_evt
                               ^ live_prev_q.tx_clock_loss_evt;               // RL6
    a2_evt[`FISL_A2_TXALIGN] = alarm2_live_status.tx_align_loss_evt
                               ^ live_prev_q.tx_align_loss_evt;               // RL6
    a2_evt[`FISL_A2_DENSITY] = tx_density_forced_evt && mode_q[`FISL_MD_DENSITY]; // RL4
    a2_evt[`FISL_A2_ONE_SECOND_TICK]  = sec_evt;                                       // RL1
    a2_evt[`FISL_A2_UNUSED]  = 1'b0;                                          // RL25
  end

  // error sources are merged before edge detection so a slip seen as
  // both types at once still gives a single rising edge
  assign slip_tx_now = err_src.tx_frame_slip || err_src.tx_uncontrolled_slip;        // RL8
  assign slip_tx_was = err_prev_q.tx_frame_slip || err_prev_q.tx_uncontrolled_slip;
  assign slip_rx_now = err_src.rx_frame_slip || err_src.rx_uncontrolled_slip;        // RL8
  assign slip_rx_was = err_prev_q.rx_frame_slip || err_prev_q.rx_uncontrolled_slip;
  assign jit_now     = err_src.tx_store_err || err_src.rx_store_err;                 // RL10
  assign jit_was     = err_prev_q.tx_store_err || err_prev_q.rx_store_err;

  always_comb
  begin
    er_evt = 8'h00;
    er_evt[`FISL_ER_TXSLIP] = slip_tx_now && !slip_tx_was;                    // RL7
    er_evt[`FISL_ER_RXSLIP] = slip_rx_now && !slip_rx_was;
    er_evt[`FISL_ER_CLKADJ] = mode_q[`FISL_MD_AUTOADJ] && err_src.jitter_clock_adjusting
                              && !err_prev_q.jitter_clock_adjusting;          // RL9
    er_evt[`FISL_ER_JITTER] = jit_now && !jit_was;                            // RL10
    er_evt[`FISL_ER_CRC]    = mode_q[`FISL_MD_CRCMODE] && err_src.block_checksum_err
                              && !err_prev_q.block_checksum_err;              // RL11
    er_evt[`FISL_ER_SIGPAT] = mode_q[`FISL_MD_E1] && err_src.signaling_pattern_err
                              && !err_prev_q.signaling_pattern_err;           // RL12
    er_evt[`FISL_ER_MFAS]   = mode_q[`FISL_MD_E1] && err_src.multiframe_pattern_err
                              && !err_prev_q.multiframe_pattern_err;          // RL12
    er_evt[`FISL_ER_FRAME]  = err_src.framing_bit_err && !err_prev_q.framing_bit_err; // RL13
  end

  // mode-gated bits read zero and request nothing while their mode is off,
  // even when they were latched before software changed the mode
  always_comb
  begin
    a2_mask                  = 8'hff;
    a2_mask[`FISL_A2_DENSITY] = mode_q[`FISL_MD_DENSITY];                    // RL4
    er_mask                  = 8'hff;
    er_mask[`FISL_ER_CLKADJ] = mode_q[`FISL_MD_AUTOADJ];                     // RL9
    er_mask[`FISL_ER_CRC]    = mode_q[`FISL_MD_CRCMODE];                     // RL11
    er_mask[`FISL_ER_SIGPAT] = mode_q[`FISL_MD_E1];                          // RL12
    er_mask[`FISL_ER_MFAS]   = mode_q[`FISL_MD_E1];                          // RL12
  end

  assign latch_vis = latch_q & {8'hff, 8'hff, er_mask, a2_mask};

  // counter_at_max is wired in the overflow bit order, msb first; a masked
  // counter records nothing, so a later enable shows no stale overflow
  genvar go;
  generate
    for (go = 0; go < 8; go++)
    begin : g_ovfl
      assign ov_evt[go] = counter_at_max[go] && !cmax_prev_q[go] && overflow_enable_q[go]; // RL14 RL16
    end
  endgenerate

  // marker rising edges; rx_signaling_update rises once per stack update
  always_comb
  begin
    tb_evt[7] = timebase_src.tx_signaling_mf_mark && !tb_prev_q.tx_signaling_mf_mark; // RL17 RL18
    tb_evt[6] = timebase_src.tx_sysbus_mf_mark && !tb_prev_q.tx_sysbus_mf_mark; // RL18
    tb_evt[5] = timebase_src.tx_multiframe_mark && !tb_prev_q.tx_multiframe_mark; // RL19
    tb_evt[4] = timebase_src.tx_frame_mark && !tb_prev_q.tx_frame_mark; // RL20
    tb_evt[3] = timebase_src.rx_signaling_update && !tb_prev_q.rx_signaling_update; // RL21
    tb_evt[2] = timebase_src.rx_sysbus_mf_mark && !tb_prev_q.rx_sysbus_mf_mark; // RL18
    tb_evt[1] = timebase_src.rx_multiframe_mark && !tb_prev_q.rx_multiframe_mark; // RL22
    tb_evt[0] = timebase_src.rx_frame_mark && !tb_prev_q.rx_frame_mark; // RL20
  end

  // same byte order as latch_q: alarm2, error, overflow, timebase from lsb
  assign set_d = {tb_evt, ov_evt, er_evt, a2_evt};

  // one latch cell per bit; a set in the clearing cycle wins over the clear
  genvar gb;
  generate
    for (gb = 0; gb < NREG * 8; gb++)
    begin : g_bit
      always_ff @(posedge mclk)
      begin
        if (srst)
        begin
          latch_q[gb] <= 1'b0;
        end
        else if (hold_en[gb / 8])
        begin
          latch_q[gb] <= set_d[gb] || (latch_q[gb] && !rd_clr[gb / 8]);     // RL15 RL17
        end
        else
        begin
          // hold mode off: the bit shows only the current event
          latch_q[gb] <= set_d[gb];                                           // RL2 RL7
        end
      end
    end
  endgenerate

  // top request bits: alarm2, error, overflow, timebase from lsb
  always_comb
  begin
    top_request_reg[0] = |(latch_vis[7:0]   & alarm2_enable_q);               // RL3 RL23
    top_request_reg[1] = |(latch_vis[15:8]  & error_enable_q);                // RL7
    top_request_reg[2] = |(latch_vis[23:16] & overflow_enable_q);             // RL14
    top_request_reg[3] = |(latch_vis[31:24] & timebase_enable_q);             // RL17
  end

  // registered so the pin cannot glitch while request bits settle
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      irq_n_q <= 1'b1;
    end
    else
    begin
      irq_n_q <= ~|top_request_reg;                                           // RL23
    end
  end

  assign irq_n = irq_n_q;

endmodule : fisl_latches

`default_nettype wire

/* test/fisl_latches_properties.sv */
// fisl_latches_properties.sv: port-level checks of the status latch block
// assumes bind to fisl_latches and alarm hold mode on when alarm2 is read just after a change
`include "fisl_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module fisl_latches_properties
  import fisl_pkg::*;
(
  input wire logic              mclk,
  input wire logic              srst,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [11:0]       wb_adr_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire fisl_alarm2_live_s alarm2_live_status,
  input wire fisl_timebase_s    timebase_src,
  input wire logic              one_second_tick,
  input wire logic              irq_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  wire logic       rd_ack = wb_ack_o && !wb_we_i;
  wire logic [9:0] idx    = wb_adr_i[11:2];
  // live detector levels placed at their alarm2 latch bit positions
  wire logic [7:0] live_pos = {alarm2_live_status[4:3], 1'b0, alarm2_live_status[2:1], 1'b0,
                               alarm2_live_status[0], 1'b0};

  property p_ack_answer;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not acked next cycle");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_dat_hold;
    !$past(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) |-> $stable(wb_dat_o);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved without a read");
  property p_upper_zero;
    rd_ack |-> wb_dat_o[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("read data above bit 7 not zero");
  property p_unused_zero;
    rd_ack && idx == `FISL_IDX_ALARM2_LATCH |-> !wb_dat_o[2];
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused alarm bit reads one");
  property p_unmapped;
    rd_ack && idx > `FISL_IDX_HOLD |-> wb_dat_o == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_irq_reset;
    $fell(srst) |-> irq_n && !wb_ack_o;
  endproperty
  a_irq_reset: assert property (p_irq_reset) else $error("request or ack out of reset");
  property p_tick_gap;
    one_second_tick |=> !one_second_tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("second tick too soon");
  property p_timebase;
    rd_ack && idx == `FISL_IDX_TIME_LATCH
      |-> (~wb_dat_o[7:0] & ~$past(timebase_src, 3) & $past(timebase_src, 2)) == 8'h00;
  endproperty
  a_timebase: assert property (p_timebase) else $error("timebase edge not latched");
  property p_alarm2_edge;
    rd_ack && idx == `FISL_IDX_ALARM2_LATCH
      |-> (~wb_dat_o[7:0] & ($past(live_pos, 3) ^ $past(live_pos, 2))) == 8'h00;
  endproperty
  a_alarm2_edge: assert property (p_alarm2_edge) else $error("alarm change not latched");
endmodule : fisl_latches_properties

bind fisl_latches fisl_latches_properties u_props (.mclk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .alarm2_live_status, .timebase_src, .one_second_tick, .irq_n);
`default_nettype wire

/* test/fisl_latches_tb.sv */
// fisl_latches_tb.sv: directed bench for the four status latches
// assumes one-cycle wishbone ack and a one-second count shrunk to 20
`include "fisl_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module fisl_latches_tb
  import fisl_pkg::*;
;
  logic        mclk = 1'b0, srst = 1'b1, cyc = 1'b0, we = 1'b0, pin = 1'b0, dens = 1'b0;
  logic [11:0] adr  = 12'h000;
  logic [31:0] wdat = 32'h0, rdat;
  logic        ack, tick, irq_n;
  logic [4:0]  live = 5'h00;
  logic [10:0] esrc = 11'h000;
  logic [7:0]  tb   = 8'h00, cmax = 8'h00;
  int          fails = 0, checked = 0, n;
  // live bit to latch bit: tx align, tx clock, short, loop up, loop down
  localparam logic [4:0][7:0] A2POS = {8'h80, 8'h40, 8'h10, 8'h08, 8'h02};
  always #5 mclk = ~mclk;
  fisl_latches #(.ONE_SECOND_TICK_CYCLES(20)) dut (.mclk(mclk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .alarm2_live_status(live), .tx_density_forced_evt(dens), .one_second_pin(pin), .err_src(esrc),
    .counter_at_max(cmax), .timebase_src(tb), .one_second_tick(tick), .irq_n(irq_n));

  task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // one classic cycle; reads compare the byte, writes ignore exp
  task automatic acc(input logic w, input logic [9:0] idx, input logic [7:0] d, input logic [7:0] exp,
                     input string nm);
    int k;
    k = 0;
    cyc  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    wdat <= {24'h0, d};
    do
      @(posedge mclk);
    while (ack !== 1'b1 && ++k < 50);
    if (k >= 50)
    begin
      fails++;
      report_and_stop();
    end
    if (!w)
      check(nm, rdat[7:0], exp);
    cyc <= 1'b0;
    @(posedge mclk);
  endtask : acc

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #100000;
    fails++;
    report_and_stop();
  end

  initial
  begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    // pin mode keeps internal ticks out of the alarm reads
    acc(1'b1, `FISL_IDX_MODE, 8'h10, 8'h00, "");
    acc(1'b0, `FISL_IDX_HOLD, 8'h00, 8'h03, "hold");
    for (int i = 5; i < 9; i++)
      acc(1'b0, 10'(i), 8'h00, 8'h00, "latch reset");
    acc(1'b0, `FISL_IDX_ALARM2_EN, 8'h00, 8'h00, "enable reset");
    acc(1'b0, 10'h100, 8'h00, 8'h00, "unmapped");
    acc(1'b1, `FISL_IDX_ALARM2_LATCH, 8'hff, 8'h00, "");
    acc(1'b0, `FISL_IDX_ALARM2_LATCH, 8'h00, 8'h00, "alarm2 write");
    cmax <= 8'h80;
    @(posedge mclk);
    cmax <= 8'h00;
    acc(1'b0, `FISL_IDX_OVFL_LATCH, 8'h00, 8'h00, "masked ovfl");
    acc(1'b1, `FISL_IDX_OVFL_EN, 8'hff, 8'h00, "");
    for (int i = 0; i < 8; i++)
    begin
      tb   <= 8'h01 << i;
      cmax <= 8'h01 << i;
      @(posedge mclk);
      tb   <= 8'h00;
      cmax <= 8'h00;
      acc(1'b0, `FISL_IDX_TIME_LATCH, 8'h00, 8'h01 << i, "timebase");
      acc(1'b0, `FISL_IDX_TIME_LATCH, 8'h00, 8'h00, "timebase clear");
      acc(1'b0, `FISL_IDX_OVFL_LATCH, 8'h00, 8'h01 << i, "ovfl");
      acc(1'b0, `FISL_IDX_OVFL_LATCH, 8'h00, 8'h00, "ovfl clear");
    end
    acc(1'b1, `FISL_IDX_OVFL_EN, 8'h00, 8'h00, "");
    check("irq idle", {7'h0, irq_n}, 8'h01);
    acc(1'b1, `FISL_IDX_TIME_EN, 8'h01, 8'h00, "");
    tb <= 8'h01;
    @(posedge mclk);
    tb <= 8'h00;
    repeat (3) @(posedge mclk);
    check("irq set", {7'h0, irq_n}, 8'h00);
    acc(1'b0, `FISL_IDX_TOP_REQ, 8'h00, 8'h08, "top request");
    acc(1'b0, `FISL_IDX_TIME_LATCH, 8'h00, 8'h01, "timebase irq");
    repeat (2) @(posedge mclk);
    check("irq clear", {7'h0, irq_n}, 8'h01);
    acc(1'b1, `FISL_IDX_TIME_EN, 8'h00, 8'h00, "");
    for (int i = 0; i < 5; i++)
    begin
      live <= 5'h01 << i;
      @(posedge mclk);
      acc(1'b0, `FISL_IDX_ALARM2_LATCH, 8'h00, A2POS[i], "alarm rise");
      live <= 5'h00;
      @(posedge mclk);
      acc(1'b0, `FISL_IDX_ALARM2_LATCH, 8'h00, A2POS[i], "alarm fall");
    end
    // hold mode 0: an alarm change shows for one cycle only
    acc(1'b1, `FISL_IDX_HOLD, 8'h00, 8'h00, "");
    live <= 5'h01;
    repeat (3) @(posedge mclk);
    live <= 5'h00;
    repeat (3) @(posedge mclk);
    acc(1'b0, `FISL_IDX_ALARM2_LATCH, 8'h00, 8'h00, "alarm no hold");
    acc(1'b1, `FISL_IDX_HOLD, 8'h03, 8'h00, "");
    acc(1'b1, `FISL_IDX_ALARM2_EN, 8'h20, 8'h00, "");
    for (int m = 0; m < 2; m++)
    begin
      acc(1'b1, `FISL_IDX_MODE, m ? 8'h18 : 8'h10, 8'h00, "");
      dens <= 1'b1;
      @(posedge mclk);
      dens <= 1'b0;
      @(posedge mclk);
      acc(1'b0, `FISL_IDX_TOP_REQ, 8'h00, m ? 8'h01 : 8'h00, "alarm2 request");
      acc(1'b0, `FISL_IDX_ALARM2_LATCH, 8'h00, m ? 8'h20 : 8'h00, "density");
    end
    acc(1'b1, `FISL_IDX_MODE, 8'h10, 8'h00, "");
    acc(1'b1, `FISL_IDX_ALARM2_EN, 8'h00, 8'h00, "");
    esrc <= 11'b10101101111;
    @(posedge mclk);
    esrc <= 11'h000;
    @(posedge mclk);
    acc(1'b0, `FISL_IDX_ERROR_LATCH, 8'h00, 8'hd1, "errors t1");
    acc(1'b1, `FISL_IDX_MODE, 8'h17, 8'h00, "");
    esrc <= 11'b01011011110;
    @(posedge mclk);
    esrc <= 11'h000;
    @(posedge mclk);
    acc(1'b0, `FISL_IDX_ERROR_LATCH, 8'h00, 8'hfe, "errors e1");
    acc(1'b1, `FISL_IDX_MODE, 8'h00, 8'h00, "");
    n = 0;
    while (tick !== 1'b1 && n++ < 60)
      @(posedge mclk);
    check("tick", {7'h0, tick}, 8'h01);
    repeat (2) @(posedge mclk);
    acc(1'b0, `FISL_IDX_ALARM2_LATCH, 8'h00, 8'h01, "timer second");
    acc(1'b1, `FISL_IDX_MODE, 8'h10, 8'h00, "");
    acc(1'b0, `FISL_IDX_ALARM2_LATCH, 8'h00, 8'h00, "pin idle");
    pin <= 1'b1;
    repeat (5) @(posedge mclk);
    acc(1'b0, `FISL_IDX_ALARM2_LATCH, 8'h00, 8'h01, "pin second");
    pin <= 1'b0;
    report_and_stop();
  end
endmodule : fisl_latches_tb
`default_nettype wire
